// ===== inc/rx_ctrl_consts.vh
// Constants for the receiver error pin, update flag and GPIO control block
`ifndef RX_CTRL_CONSTS_VH
`define RX_CTRL_CONSTS_VH
// ==========================================================================
// Serial control bus
`define BUS_DEVICE_ADDR 8'hE8
`define CMD_INT_CONTENTS 6'h20
`define CMD_ERROR_PIN_CONFIG 6'h24
`define CMD_GPIO_OUTPUT_LEVELS 6'h28
`define CMD_WORD_BITS 5'h10
// ==========================================================================
// Register indexes (command numbers)
`define REG_INT_CONTENTS 4'h8
`define REG_ERROR_PIN_CONFIG 4'h9
`define REG_GPIO_OUTPUT_LEVELS 4'hA
// ==========================================================================
// Field positions in the 16-bit word
`define CMD_CODE_HI 7
`define CMD_CODE_LO 2
`define CHIP_SEL_UPPER_BIT 1
`define CHIP_SEL_LOWER_BIT 0
`define INT_INPUT_DETECT_BIT 9
`define INT_CS_UPDATE_BIT 11
`define INT_PC_UPDATE_BIT 13
`define INT_GPIO_UPDATE_BIT 14
`define ERR_SOURCE_BIT 8
`define ERR_PARITY_MODE_BIT 9
`define ERR_FORCE_BIT 12
`define ERR_RATE_MASK_BIT 13
`define ERR_WAIT_HI 15
`define ERR_WAIT_LO 14
`define GPIO_LEVEL_HI 15
`define GPIO_LEVEL_LO 12
// ==========================================================================
// Reset values
`define FIELD_RESET 1'h0
`define WAIT_RESET 2'h0
`define GPIO_RESET 4'h0
// ==========================================================================
// Release wait in block-start preambles
`define WAIT_CODE0_COUNT 5'h03
`define WAIT_CODE1_COUNT 5'h18
`define WAIT_CODE2_COUNT 5'h18
`define WAIT_CODE3_COUNT 5'h18
// ==========================================================================
// Timing
`define CS_COMPARE_BITS 48
`define PC_COMPARE_BITS 16
`define GPIO_WIDTH 4
`define SYS_CLK_HZ 200000000
`define GPIO_SAMPLE_HZ 24000
`define XTAL_HZ 24576000
`endif

// ===== design/sync_two_stage.v
// Two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
module sync_two_stage #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire nrst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // ==========================================================================
  // Only the second stage is visible to the rest of the design
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // sync_two_stage

// ===== design/rx_error_control.v
// Receive error pin, update flags and GPIO levels behind the serial control bus
// Operation
// - Input detection flag only with its enable, crystal source with 24.576MHz and monitor on.
// - Channel-status update flag rises when first 48 bits match those of previous block.
// - Pc update flag rises when the 16-bit burst preamble Pc equals the previous one.
// - In parallel input mode the 4 GPIO pins are sampled at 24kHz; a change raises a flag.
// - Command 9 at address 0xE8 code 100100 carries error-pin fields in 15:12, 9 and 8.
// - When non-PCM counts as an error, output data is muted while that error is present.
// - Forcing the error while the crystal is selected affects only the error pin.
// - Rate changes measured with the oscillator stopped are ignored; only channel status counts.
// - After lock the error pin releases after 3 (code 00) or 24 (code 01) block preambles.
// - Demodulated data stays muted until the block-preamble release wait ends.
// - In parallel output mode each GPIO pin drives low for 0 and high for 1 of bits 12-15.
`timescale 1ns/10ps
`include "rx_ctrl_consts.vh"
module rx_error_control #(
  parameter GPIO_SAMPLE_DIV = `SYS_CLK_HZ / `GPIO_SAMPLE_HZ,
  parameter [4:0] WAIT_CODE2_COUNT = `WAIT_CODE2_COUNT,
  parameter [4:0] WAIT_CODE3_COUNT = `WAIT_CODE3_COUNT
) (
  input wire CLK_SYS,
  input wire NRST,
  input wire BUS_CLK,
  input wire BUS_DATA,
  input wire BUS_CE,
  input wire [1:0] CHIP_ADDR_STRAP,
  input wire CRYSTAL_SOURCE_SELECT,
  input wire INPUT_MONITOR_ENABLE,
  input wire CRYSTAL_RATE_OK,
  input wire INPUT_CHANGE,
  input wire CS_VALID,
  input wire [47:0] CS_BITS,
  input wire PC_VALID,
  input wire [15:0] PC_WORD,
  input wire GPIO_PARALLEL_INPUT,
  input wire [3:0] GPIO_IN,
  input wire BLOCK_START,
  input wire PLL_LOCK,
  input wire DATA_ERROR,
  input wire NON_PCM,
  input wire PARITY_ERROR,
  input wire OSC_RUNNING,
  input wire FS_CHANGE_MEASURED,
  input wire FS_CHANGE_CS,
  output reg INPUT_DETECT_FLAG,
  output reg CS_UPDATE_FLAG,
  output reg PC_UPDATE_FLAG,
  output reg GPIO_UPDATE_FLAG,
  output reg RECEIVE_ERROR,
  output reg PARITY_FLAG,
  output reg DATA_MUTE,
  output reg [3:0] GPIO_OUT,
  output reg [3:0] GPIO_OE
);
  // ==========================================================================
  // Pin synchronisers
  wire [2:0] bus_s;
  wire [1:0] strap_s;
  wire [3:0] gpio_s;

  sync_two_stage #(.WIDTH(9)) u_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .async_in({GPIO_IN, CHIP_ADDR_STRAP, BUS_CE, BUS_DATA, BUS_CLK}),
    .sync_out({gpio_s, strap_s, bus_s})
  );

  // ==========================================================================
  // Serial control bus receiver
  reg bus_clk_d;
  reg bus_ce_d;
  reg [7:0] addr_shift;
  reg [15:0] data_shift;
  reg [4:0] bit_count;
  reg addr_match;
  wire bus_rise = bus_s[0] & ~bus_clk_d;
  wire ce_rise = bus_s[2] & ~bus_ce_d;
  wire ce_fall = ~bus_s[2] & bus_ce_d;
  wire [5:0] cmd_code = data_shift[`CMD_CODE_HI:`CMD_CODE_LO];
  wire chip_ok = (data_shift[`CHIP_SEL_UPPER_BIT] == strap_s[1]) &&
                 (data_shift[`CHIP_SEL_LOWER_BIT] == strap_s[0]);
  // Long or short words never reach the settings
  wire word_done = ce_fall && addr_match && (bit_count == `CMD_WORD_BITS) && chip_ok;

  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      bus_clk_d <= 1'b0;
      bus_ce_d <= 1'b0;
      addr_shift <= 8'h00;
      data_shift <= 16'h0000;
      bit_count <= 5'h00;
      addr_match <= 1'b0;
    end else begin
      bus_clk_d <= bus_s[0];
      bus_ce_d <= bus_s[2];
      if (ce_rise) begin
        addr_match <= (addr_shift == `BUS_DEVICE_ADDR);
        bit_count <= 5'h00;
      end else if (bus_rise && !bus_s[2]) begin
        addr_shift <= {bus_s[1], addr_shift[7:1]};
      end else if (bus_rise && bus_s[2]) begin
        data_shift <= {bus_s[1], data_shift[15:1]};
        if (bit_count != 5'h1F) begin
          bit_count <= bit_count + 5'h01;
        end
      end
      if (ce_fall) begin
        addr_match <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Command registers
  reg input_detect_flag_enable;
  reg cs_update_enable;
  reg pc_update_enable;
  reg gpio_update_enable;
  reg error_source_select;
  reg parity_flag_mode;
  reg error_force_select;
  reg rate_change_error_mask;
  reg [1:0] error_release_wait;
  reg [3:0] gpio_out_level;

  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      input_detect_flag_enable <= `FIELD_RESET;
      cs_update_enable <= `FIELD_RESET;
      pc_update_enable <= `FIELD_RESET;
      gpio_update_enable <= `FIELD_RESET;
      error_source_select <= `FIELD_RESET;
      parity_flag_mode <= `FIELD_RESET;
      error_force_select <= `FIELD_RESET;
      rate_change_error_mask <= `FIELD_RESET;
      error_release_wait <= `WAIT_RESET;
      gpio_out_level <= `GPIO_RESET;
    end else if (word_done) begin
      case (cmd_code)
        `CMD_INT_CONTENTS: begin
          input_detect_flag_enable <= data_shift[`INT_INPUT_DETECT_BIT];
          cs_update_enable <= data_shift[`INT_CS_UPDATE_BIT];
          pc_update_enable <= data_shift[`INT_PC_UPDATE_BIT];
          gpio_update_enable <= data_shift[`INT_GPIO_UPDATE_BIT];
        end
        `CMD_ERROR_PIN_CONFIG: begin
          error_source_select <= data_shift[`ERR_SOURCE_BIT];
          parity_flag_mode <= data_shift[`ERR_PARITY_MODE_BIT];
          error_force_select <= data_shift[`ERR_FORCE_BIT];
          rate_change_error_mask <= data_shift[`ERR_RATE_MASK_BIT];
          error_release_wait <= data_shift[`ERR_WAIT_HI:`ERR_WAIT_LO];
        end
        `CMD_GPIO_OUTPUT_LEVELS: begin
          gpio_out_level <= data_shift[`GPIO_LEVEL_HI:`GPIO_LEVEL_LO];
        end
        default: begin
          gpio_out_level <= gpio_out_level;
        end
      endcase
    end
  end

  // ==========================================================================
  // Update flags
  reg [47:0] cs_prev;
  reg [15:0] pc_prev;
  reg [3:0] gpio_prev;
  reg [13:0] sample_count;
  wire sample_tick = (sample_count == 14'h0000);
  wire detect_ok = input_detect_flag_enable & CRYSTAL_SOURCE_SELECT & CRYSTAL_RATE_OK &
                   INPUT_MONITOR_ENABLE;

  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cs_prev <= 48'h000000000000;
      pc_prev <= 16'h0000;
      gpio_prev <= 4'h0;
      sample_count <= 14'h0000;
      INPUT_DETECT_FLAG <= 1'b0;
      CS_UPDATE_FLAG <= 1'b0;
      PC_UPDATE_FLAG <= 1'b0;
      GPIO_UPDATE_FLAG <= 1'b0;
    end else begin
      INPUT_DETECT_FLAG <= detect_ok & INPUT_CHANGE;
      CS_UPDATE_FLAG <= cs_update_enable & CS_VALID & (CS_BITS == cs_prev);
      PC_UPDATE_FLAG <= pc_update_enable & PC_VALID & (PC_WORD == pc_prev);
      if (CS_VALID) begin
        cs_prev <= CS_BITS;
      end
      if (PC_VALID) begin
        pc_prev <= PC_WORD;
      end
      // Divider is free running so sampling stays on a steady 24kHz grid
      if (sample_count == GPIO_SAMPLE_DIV[13:0] - 14'h0001) begin
        sample_count <= 14'h0000;
      end else begin
        sample_count <= sample_count + 14'h0001;
      end
      GPIO_UPDATE_FLAG <= gpio_update_enable & GPIO_PARALLEL_INPUT & sample_tick &
                          (gpio_s != gpio_prev);
      if (sample_tick) begin
        gpio_prev <= gpio_s;
      end
    end
  end

  // ==========================================================================
  // Receive error pin and release wait
  reg [4:0] block_count;
  reg released;
  reg [4:0] wait_target;
  // Stopped oscillator gives a meaningless rate, so only channel status counts then
  wire fs_change = ~rate_change_error_mask &
                   ((FS_CHANGE_MEASURED & OSC_RUNNING) | FS_CHANGE_CS);
  wire nonpcm_err = error_source_select & NON_PCM;
  wire raw_error = ~PLL_LOCK | DATA_ERROR | nonpcm_err | fs_change;

  always @* begin
    case (error_release_wait)
      2'b00: wait_target = `WAIT_CODE0_COUNT;
      2'b01: wait_target = `WAIT_CODE1_COUNT;
      2'b10: wait_target = WAIT_CODE2_COUNT;
      default: wait_target = WAIT_CODE3_COUNT;
    endcase
  end

  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      block_count <= 5'h00;
      released <= 1'b0;
      RECEIVE_ERROR <= 1'b1;
      DATA_MUTE <= 1'b1;
      PARITY_FLAG <= 1'b0;
    end else begin
      if (raw_error) begin
        block_count <= 5'h00;
        released <= 1'b0;
      end else if (!released && BLOCK_START) begin
        if (block_count + 5'h01 >= wait_target) begin
          released <= 1'b1;
        end
        block_count <= block_count + 5'h01;
      end
      // Forced error reaches the pin only; muting follows the real state
      RECEIVE_ERROR <= ~released | (error_force_select & CRYSTAL_SOURCE_SELECT);
      DATA_MUTE <= ~released | raw_error;
      PARITY_FLAG <= PARITY_ERROR & (parity_flag_mode | NON_PCM);
    end
  end

  // ==========================================================================
  // GPIO output drivers
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      GPIO_OUT <= 4'h0;
      GPIO_OE <= 4'h0;
    end else begin
      GPIO_OUT <= gpio_out_level;
      GPIO_OE <= {`GPIO_WIDTH{~GPIO_PARALLEL_INPUT}};
    end
  end
endmodule // rx_error_control

// ===== verification/rx_error_control_asserts.sv
// Concurrent checks on the ports of the receiver error and GPIO block
`timescale 1ns/10ps
module rx_error_control_asserts (
  input wire CLK_SYS,
  input wire NRST,
  input wire BUS_CE,
  input wire CRYSTAL_SOURCE_SELECT,
  input wire INPUT_MONITOR_ENABLE,
  input wire CRYSTAL_RATE_OK,
  input wire INPUT_CHANGE,
  input wire CS_VALID,
  input wire PC_VALID,
  input wire GPIO_PARALLEL_INPUT,
  input wire BLOCK_START,
  input wire PLL_LOCK,
  input wire DATA_ERROR,
  input wire INPUT_DETECT_FLAG,
  input wire CS_UPDATE_FLAG,
  input wire PC_UPDATE_FLAG,
  input wire GPIO_UPDATE_FLAG,
  input wire RECEIVE_ERROR,
  input wire DATA_MUTE,
  input wire [3:0] GPIO_OUT,
  input wire [3:0] GPIO_OE
);
  // ==========================================================================
  // Port relations
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  detect_cause_a: assert property (
    INPUT_DETECT_FLAG |-> $past(INPUT_CHANGE && CRYSTAL_SOURCE_SELECT
    && INPUT_MONITOR_ENABLE && CRYSTAL_RATE_OK)) else $error("detect flag without cause");
  cs_flag_a: assert property (CS_UPDATE_FLAG |-> $past(CS_VALID))
    else $error("cs flag without block");
  pc_flag_a: assert property (PC_UPDATE_FLAG |-> $past(PC_VALID))
    else $error("pc flag without block");
  gpio_flag_a: assert property (
    GPIO_UPDATE_FLAG |-> $past(GPIO_PARALLEL_INPUT) ##1 !GPIO_UPDATE_FLAG)
    else $error("gpio flag wrong");
  gpio_dir_a: assert property (
    1'b1 |=> GPIO_OE == {4{!$past(GPIO_PARALLEL_INPUT)}}) else $error("gpio enable wrong");
  gpio_word_a: assert property ($changed(GPIO_OUT) |-> !BUS_CE)
    else $error("gpio changed mid word");
  lock_error_a: assert property (!PLL_LOCK |-> ##[1:2] RECEIVE_ERROR)
    else $error("error pin low without lock");
  error_mute_a: assert property (DATA_ERROR |-> ##[1:2] DATA_MUTE)
    else $error("data not muted on error");
  mute_release_a: assert property (
    $fell(DATA_MUTE) |-> $past(BLOCK_START, 2) || $past(BLOCK_START, 3))
    else $error("mute released off preamble");
  reset_state_a: assert property (
    !$past(NRST) |-> RECEIVE_ERROR && DATA_MUTE && GPIO_OUT == 4'h0)
    else $error("reset state wrong");
endmodule // rx_error_control_asserts

bind rx_error_control rx_error_control_asserts u_asserts (.*);

// ===== verification/serial_host.sv
// Host model driving the serial control bus
`timescale 1ns/10ps
module serial_host (
  output logic bus_clk,
  output logic bus_data,
  output logic bus_ce
);
  // ==========================================================================
  // Frames
  initial begin
    bus_clk = 1'h0;
    bus_data = 1'h0;
    bus_ce = 1'h0;
  end
  // Link clock runs only inside frames; data moves while it is low
  task automatic put(input b);
    bus_data = b;
    #62.5 bus_clk = 1'h1;
    #62.5 bus_clk = 1'h0;
  endtask
  // Address with enable low, then n data bits with enable high, LSB first
  task automatic send(input [7:0] a, input [15:0] w, input int n);
    int i;
    bus_ce = 1'h0;
    for (i = 0; i < 8; i++) put(a[i]);
    #62.5 bus_ce = 1'h1;
    for (i = 0; i < n; i++) put(w[i % 16]);
    #62.5 bus_ce = 1'h0;
    // Released line must not keep a stale level
    bus_data = ~bus_data;
    #500;
  endtask
endmodule // serial_host

// ===== verification/test_receiver_error_flag_gpio_control.sv
// Self-checking bench for the receiver error pin, flag and GPIO block
`timescale 1ns/10ps
`include "rx_ctrl_consts.vh"
module test_receiver_error_flag_gpio_control;
  typedef struct packed {
    logic [7:0] a;
    logic [5:0] c;
    logic [7:0] d;
    logic [1:0] s;
    logic [4:0] n;
    logic [3:0] e;
  } row_t;
  logic CLK_SYS = 1'h0, NRST = 1'h0, CRYSTAL_SOURCE_SELECT = 1'h0, INPUT_MONITOR_ENABLE = 1'h0;
  logic CRYSTAL_RATE_OK = 1'h0, INPUT_CHANGE = 1'h0, CS_VALID = 1'h0, PC_VALID = 1'h0;
  logic GPIO_PARALLEL_INPUT = 1'h0, PLL_LOCK = 1'h0, DATA_ERROR = 1'h0, NON_PCM = 1'h0;
  logic PARITY_ERROR = 1'h0, BLOCK_START = 1'h0, OSC_RUNNING = 1'h0;
  logic FS_CHANGE_MEASURED = 1'h0, FS_CHANGE_CS = 1'h0;
  logic [1:0] CHIP_ADDR_STRAP = 2'h2;
  logic [3:0] GPIO_IN = 4'h0;
  logic [15:0] PC_WORD = 16'h0;
  logic [47:0] CS_BITS = 48'h0;
  wire BUS_CLK, BUS_DATA, BUS_CE, INPUT_DETECT_FLAG, CS_UPDATE_FLAG, PC_UPDATE_FLAG;
  wire GPIO_UPDATE_FLAG, RECEIVE_ERROR, PARITY_FLAG, DATA_MUTE;
  wire [3:0] GPIO_OUT, GPIO_OE;
  int error_cnt = 0, check_count = 0;
  // Short sample divider keeps the run brief
  rx_error_control #(.GPIO_SAMPLE_DIV(16)) u_rx_error_control (.*);
  serial_host u_serial_host (.bus_clk(BUS_CLK), .bus_data(BUS_DATA), .bus_ce(BUS_CE));
  row_t rows [7] = '{
    '{8'hE8, `CMD_GPIO_OUTPUT_LEVELS, 8'hA0, 2'h2, 5'h10, 4'hA},
    '{8'hE8, `CMD_GPIO_OUTPUT_LEVELS, 8'h50, 2'h2, 5'h10, 4'h5},
    '{8'hE8, `CMD_GPIO_OUTPUT_LEVELS, 8'hF0, 2'h2, 5'h0F, 4'h5},
    '{8'hE8, `CMD_GPIO_OUTPUT_LEVELS, 8'hF0, 2'h2, 5'h11, 4'h5},
    '{8'hE8, `CMD_GPIO_OUTPUT_LEVELS, 8'h30, 2'h1, 5'h10, 4'h5},
    '{8'hE9, `CMD_GPIO_OUTPUT_LEVELS, 8'h30, 2'h2, 5'h10, 4'h5},
    '{8'hE8, `CMD_ERROR_PIN_CONFIG, 8'hF0, 2'h2, 5'h10, 4'h5}};
  always #2.5 CLK_SYS = ~CLK_SYS;
  // ==========================================================================
  // Helpers
  task automatic check(input [15:0] seen, input [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic cmd(input [5:0] c, input [7:0] d);
    u_serial_host.send(8'hE8, {d, c, 2'h2}, 16);
    tick(1);
  endtask
  task automatic pulse3(input [2:0] v, input [2:0] e);
    {CS_VALID, PC_VALID, INPUT_CHANGE} = v;
    tick(1);
    {CS_VALID, PC_VALID, INPUT_CHANGE} = 3'h0;
    check({CS_UPDATE_FLAG, PC_UPDATE_FLAG, INPUT_DETECT_FLAG}, e, "flags");
    tick(1);
  endtask
  task automatic count_gpio(input [3:0] e);
    logic [15:0] n;
    n = 16'h0000;
    // Four-state count so an unknown flag cannot pass as zero
    repeat (100) begin
      tick(1);
      n += GPIO_UPDATE_FLAG;
    end
    check(n, e, "gpio_flags");
  endtask
  task automatic blocks(input int n);
    repeat (n) begin
      BLOCK_START = 1'h1;
      tick(1);
      BLOCK_START = 1'h0;
      tick(3);
    end
  endtask
  task automatic pulse_fs(input cs);
    {FS_CHANGE_CS, FS_CHANGE_MEASURED} = {cs, !cs};
    tick(1);
    {FS_CHANGE_CS, FS_CHANGE_MEASURED} = 2'h0;
    tick(3);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (3) @(posedge CLK_SYS);
    #1 check({RECEIVE_ERROR, DATA_MUTE, GPIO_OUT, GPIO_OE}, 10'h300, "reset");
    NRST = 1'h1;
    tick(2);
    check(GPIO_OE, 4'hF, "gpio_oe");
    foreach (rows[i]) begin
      u_serial_host.send(rows[i].a, {rows[i].d, rows[i].c, rows[i].s}, rows[i].n);
      check(GPIO_OUT, rows[i].e, "gpio_out");
    end
    $display("rows done");
    CS_BITS = 48'hA5;
    PC_WORD = 16'h1C;
    pulse3(3'h6, 3'h0);
    cmd(`CMD_INT_CONTENTS, 8'h6A);
    CS_BITS = 48'h5A;
    PC_WORD = 16'hC1;
    pulse3(3'h6, 3'h0);
    pulse3(3'h6, 3'h6);
    for (int i = 0; i < 4; i++) begin
      {CRYSTAL_SOURCE_SELECT, INPUT_MONITOR_ENABLE, CRYSTAL_RATE_OK} = 3'h7 & ~(3'h1 << i);
      pulse3(3'h1, {2'h0, i == 3});
    end
    GPIO_PARALLEL_INPUT = 1'h1;
    tick(2);
    check(GPIO_OE, 4'h0, "gpio_oe");
    GPIO_IN = 4'h6;
    count_gpio(4'h1);
    count_gpio(4'h0);
    $display("flags done");
    PLL_LOCK = 1'h1;
    cmd(`CMD_ERROR_PIN_CONFIG, 8'h00);
    blocks(2);
    check(RECEIVE_ERROR, 1'h1, "error_pin");
    blocks(1);
    check({RECEIVE_ERROR, DATA_MUTE}, 2'h0, "release");
    pulse_fs(1'h0);
    check(RECEIVE_ERROR, 1'h0, "osc_stopped");
    // A running oscillator makes the measured rate count again
    OSC_RUNNING = 1'h1;
    pulse_fs(1'h0);
    check(RECEIVE_ERROR, 1'h1, "osc_running");
    OSC_RUNNING = 1'h0;
    blocks(3);
    cmd(`CMD_ERROR_PIN_CONFIG, 8'h10);
    check({RECEIVE_ERROR, DATA_MUTE}, 2'h2, "forced");
    cmd(`CMD_ERROR_PIN_CONFIG, 8'h40);
    check(RECEIVE_ERROR, 1'h0, "unforced");
    pulse_fs(1'h1);
    check(RECEIVE_ERROR, 1'h1, "cs_rate");
    DATA_ERROR = 1'h1;
    tick(1);
    DATA_ERROR = 1'h0;
    blocks(23);
    check(DATA_MUTE, 1'h1, "wait24");
    blocks(1);
    check({RECEIVE_ERROR, DATA_MUTE}, 2'h0, "release24");
    // Non-PCM only counts as an error once the source select asks for it
    PARITY_ERROR = 1'h1;
    NON_PCM = 1'h1;
    tick(2);
    check({RECEIVE_ERROR, DATA_MUTE, PARITY_FLAG}, 3'h1, "nonpcm_ignored");
    NON_PCM = 1'h0;
    tick(2);
    check(PARITY_FLAG, 1'h0, "parity_pcm");
    cmd(`CMD_ERROR_PIN_CONFIG, 8'h03);
    check(PARITY_FLAG, 1'h1, "parity_always");
    NON_PCM = 1'h1;
    tick(2);
    check({RECEIVE_ERROR, DATA_MUTE}, 2'h3, "nonpcm_mute");
    NON_PCM = 1'h0;
    blocks(3);
    check({RECEIVE_ERROR, DATA_MUTE}, 2'h0, "nonpcm_release");
    $display("error pin done");
    // Reset in mid-run must drop every field written so far
    NRST = 1'h0;
    tick(2);
    check({RECEIVE_ERROR, DATA_MUTE, GPIO_OUT, PARITY_FLAG}, 7'h60, "reset2");
    NRST = 1'h1;
    CS_BITS = 48'h0;
    PC_WORD = 16'h0;
    tick(2);
    pulse3(3'h7, 3'h0);
    check(PARITY_FLAG, 1'h0, "parity_reset");
    $display("reset done");
    tally_and_finish;
  end
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish;
  end
endmodule // test_receiver_error_flag_gpio_control
